// ==== design/fcr_config_regs.sv ====
// Floppy controller configuration bank with an AHB-Lite slave port.
// Assumes a single-master AHB-Lite bus on clk_sys; zero-wait answers.
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none

module fcr_config_regs #(
	parameter int ADDR_W = 32
) (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clkEn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Global enables, same clock
	input wire logic globalConfigOneEn,
	input wire logic globalConfigSixEn,
	// Floppy core status
	input wire logic driveSelect,
	input wire logic highRate,
	// Write-protect pin, asynchronous
	input wire logic writeProtect_n,
	// Resource settings to the core
	output logic [15:0] baseAddress,
	output logic [7:0] irqNumberWake,
	output logic [7:0] irqTypeSel,
	output logic [7:0] dmaChannel,
	output logic deviceActive,
	// Drive controls
	output logic [5:0] tapeDriveHigh,
	output logic enhancedMode,
	output logic densitySelectOut,
	output logic writeBlocked,
	output logic altDriveMode,
	output logic outputsHiZ
);
	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	if (ADDR_W < 10) begin : g_bad_width
		$error("ADDR_W must cover the register window");
	end

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0] activate_reg;
	logic [7:0] activate_next;
	logic [7:0] baseHigh_reg;
	logic [7:0] baseHigh_next;
	logic [7:0] baseLow_reg;
	logic [7:0] baseLow_next;
	logic [7:0] irqNum_reg;
	logic [7:0] irqNum_next;
	logic [7:0] irqType_reg;
	logic [7:0] irqType_next;
	logic [7:0] dmaSel_reg;
	logic [7:0] dmaSel_next;
	logic [7:0] cfg_reg;
	logic [7:0] cfg_next;
	logic [7:0] ident_reg;
	logic [7:0] ident_next;

	// Bus bookkeeping
	logic wrPend_reg;
	logic [7:0] wrIdx_reg;
	logic [31:0] rdData_reg;
	logic accept;
	logic inWindow;
	logic [7:0] reqIdx;
	logic [7:0] rdByte;
	logic wpMeta_reg;
	logic wpSync_reg;
	logic active_reg;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Masked byte update, used by the registers with read-only bits
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data,
			input logic [7:0] mask);
		merge = (old & ~mask) | (data & mask);
	endfunction : merge

	// ----------------------------------------
	// Address phase decode
	// ----------------------------------------
	// Byte lanes below a word and the high address must be zero
	assign reqIdx = haddr[9:2];
	assign inWindow = (haddr[1:0] == 2'b00) && (haddr >> 10 == '0);
	assign accept = hsel && htrans[1] && hready && clkEn;

	// Never stalls by itself; a frozen clock enable holds the bus
	assign hreadyout = clkEn;
	assign hresp = 1'b0;
	assign hrdata = rdData_reg;

	// Capture of a write for its data phase
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			wrPend_reg <= 1'b0;
			wrIdx_reg <= 8'h00;
		end else if (clkEn) begin
			wrPend_reg <= accept && hwrite && inWindow;
			wrIdx_reg <= reqIdx;
		end
	end

	// ----------------------------------------
	// Data phase write, next values
	// ----------------------------------------
	// Only the low byte carries data; unmapped indexes are ignored
	always_comb begin
		activate_next = activate_reg;
		baseHigh_next = baseHigh_reg;
		baseLow_next = baseLow_reg;
		irqNum_next = irqNum_reg;
		irqType_next = irqType_reg;
		dmaSel_next = dmaSel_reg;
		cfg_next = cfg_reg;
		ident_next = ident_reg;
		if (wrPend_reg) begin
			case (wrIdx_reg)
				fcr_pkg::IDX_ACTIVATE: activate_next = hwdata[7:0];
				fcr_pkg::IDX_BASE_HIGH: baseHigh_next = merge(baseHigh_reg, hwdata[7:0],
					fcr_pkg::WMASK_BASE_HIGH);
				fcr_pkg::IDX_BASE_LOW: baseLow_next = merge(baseLow_reg, hwdata[7:0],
					fcr_pkg::WMASK_BASE_LOW);
				fcr_pkg::IDX_IRQ_NUM: irqNum_next = hwdata[7:0];
				fcr_pkg::IDX_IRQ_TYPE: irqType_next = merge(irqType_reg, hwdata[7:0],
					fcr_pkg::WMASK_IRQ_TYPE);
				fcr_pkg::IDX_DMA_SEL: dmaSel_next = hwdata[7:0];
				// Reserved bits 7, 4 and 1 are kept at zero even if written
				fcr_pkg::IDX_CFG: cfg_next = merge(cfg_reg, hwdata[7:0], fcr_pkg::WMASK_CFG);
				fcr_pkg::IDX_IDENT: ident_next = merge(ident_reg, hwdata[7:0],
					fcr_pkg::WMASK_IDENT);
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	// Hardware reset loads the documented defaults
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			activate_reg <= fcr_pkg::RST_ACTIVATE;
			baseHigh_reg <= fcr_pkg::RST_BASE_HIGH;
			baseLow_reg <= fcr_pkg::RST_BASE_LOW;
			irqNum_reg <= fcr_pkg::RST_IRQ_NUM;
			irqType_reg <= fcr_pkg::RST_IRQ_TYPE;
			dmaSel_reg <= fcr_pkg::RST_DMA_SEL;
			cfg_reg <= fcr_pkg::RST_CFG;
			ident_reg <= fcr_pkg::RST_IDENT;
		end else if (clkEn) begin
			activate_reg <= activate_next;
			baseHigh_reg <= baseHigh_next;
			baseLow_reg <= baseLow_next;
			irqNum_reg <= irqNum_next;
			irqType_reg <= irqType_next;
			dmaSel_reg <= dmaSel_next;
			cfg_reg <= cfg_next;
			ident_reg <= ident_next;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Reads sample next values, so a write just before is seen
	always_comb begin
		rdByte = 8'h00;
		if (inWindow) begin
			case (reqIdx)
				fcr_pkg::IDX_ACTIVATE: rdByte = activate_next;
				fcr_pkg::IDX_BASE_HIGH: rdByte = baseHigh_next;
				fcr_pkg::IDX_BASE_LOW: rdByte = baseLow_next;
				fcr_pkg::IDX_IRQ_NUM: rdByte = irqNum_next;
				fcr_pkg::IDX_IRQ_TYPE: rdByte = irqType_next;
				fcr_pkg::IDX_DMA_SEL: rdByte = dmaSel_next;
				fcr_pkg::IDX_DMA2_RPT: rdByte = fcr_pkg::VAL_DMA2_RPT;
				fcr_pkg::IDX_CFG: rdByte = cfg_next;
				fcr_pkg::IDX_IDENT: rdByte = ident_next;
				default: rdByte = 8'h00;
			endcase
		end
	end

	// Read data held until the next read is taken
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rdData_reg <= 32'h0000_0000;
		end else if (clkEn && accept && !hwrite) begin
			rdData_reg <= {24'h00_0000, rdByte};
		end
	end

	// ----------------------------------------
	// Pin synchroniser and activity
	// ----------------------------------------
	// Protect pin is asynchronous; second stage only is used
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			wpMeta_reg <= 1'b0;
			wpSync_reg <= 1'b0;
		end else if (clkEn) begin
			wpMeta_reg <= ~writeProtect_n;
			wpSync_reg <= wpMeta_reg;
		end
	end

	// Device active needs its own bit and both global enables
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			active_reg <= 1'b0;
		end else if (clkEn) begin
			active_reg <= activate_reg[fcr_pkg::ACT_ENABLE] && globalConfigOneEn
				&& globalConfigSixEn;
		end
	end

	// ----------------------------------------
	// Outputs to the core
	// ----------------------------------------
	assign baseAddress = {baseHigh_reg, baseLow_reg};
	assign irqNumberWake = irqNum_reg;
	assign irqTypeSel = irqType_reg;
	assign dmaChannel = dmaSel_reg;
	assign deviceActive = active_reg;
	assign enhancedMode = cfg_reg[fcr_pkg::CFG_ENHANCED];

	// Drive-facing controls
	fcr_drive_ctrl u_drive (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.clkEn(clkEn),
		.cfgValue(cfg_reg),
		.identValue(ident_reg[3:0]),
		.devActive(active_reg),
		.driveSelect(driveSelect),
		.highRate(highRate),
		.writeProtectSync(wpSync_reg),
		.tapeDriveHigh(tapeDriveHigh),
		.densitySelectOut(densitySelectOut),
		.writeBlocked(writeBlocked),
		.altDriveMode(altDriveMode),
		.outputsHiZ(outputsHiZ)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	logic wrOk;
	logic rdOk;
	assign wrOk = wrPend_reg && clkEn;
	assign rdOk = accept && !hwrite && inWindow;

	property p_cfg_reset;
		@(posedge clk_sys) disable iff (1'b0)
		!reset_n |=> cfg_reg == 8'h24 && baseAddress == 16'h03f2 && ident_reg == 8'h00;
	endproperty
	a_cfg_reset: assert property (p_cfg_reset) else $error("reset values wrong");

	property p_res_reset;
		@(posedge clk_sys) disable iff (1'b0)
		!reset_n |=> irqNumberWake == 8'h06 && irqTypeSel == 8'h03 && dmaChannel == 8'h02
			&& activate_reg == 8'h00;
	endproperty
	a_res_reset: assert property (p_res_reset) else $error("resource resets wrong");

	property p_base_high;
		wrOk && wrIdx_reg == 8'h60 |=> baseAddress[15:8] == {5'h00, $past(hwdata[2:0])};
	endproperty
	a_base_high: assert property (p_base_high) else $error("base high write wrong");

	property p_base_low;
		wrOk && wrIdx_reg == 8'h61 |=> baseAddress[7:0] == ($past(hwdata[7:0]) & 8'hfa);
	endproperty
	a_base_low: assert property (p_base_low) else $error("base low write wrong");

	property p_irq_type;
		wrOk && wrIdx_reg == 8'h71 |=> irqTypeSel == {6'h00, $past(hwdata[1]), 1'b1};
	endproperty
	a_irq_type: assert property (p_irq_type) else $error("irq type write wrong");

	property p_dma2;
		rdOk && reqIdx == fcr_pkg::IDX_DMA2_RPT ##1 clkEn |-> hrdata == 32'h0000_0004;
	endproperty
	a_dma2: assert property (p_dma2) else $error("second dma report wrong");

	property p_ident;
		wrOk && wrIdx_reg == 8'hf1 |=> ident_reg == {4'h0, $past(hwdata[3:0])};
	endproperty
	a_ident: assert property (p_ident) else $error("ident write wrong");

	property p_dma_sel;
		wrOk && wrIdx_reg == 8'h74 |=> dmaChannel == $past(hwdata[7:0]);
	endproperty
	a_dma_sel: assert property (p_dma_sel) else $error("dma select write wrong");

	property p_active;
		clkEn && activate_reg[0] && globalConfigOneEn && globalConfigSixEn |=> deviceActive;
	endproperty
	a_active: assert property (p_active) else $error("device not active");

	property p_wp_sync;
		clkEn && !writeProtect_n ##1 clkEn ##1 clkEn && !cfg_reg[3] |=> writeBlocked;
	endproperty
	a_wp_sync: assert property (p_wp_sync) else $error("pin protect lost");

	// Plain read/write registers take the whole low byte
	property p_irq_num;
		wrOk && wrIdx_reg == fcr_pkg::IDX_IRQ_NUM |=> irqNumberWake == $past(hwdata[7:0]);
	endproperty
	a_irq_num: assert property (p_irq_num) else $error("irq number write wrong");

	property p_act_write;
		wrOk && wrIdx_reg == fcr_pkg::IDX_ACTIVATE |=> activate_reg == $past(hwdata[7:0]);
	endproperty
	a_act_write: assert property (p_act_write) else $error("activate write wrong");

	property p_okay;
		hresp == 1'b0 && hreadyout == clkEn;
	endproperty
	a_okay: assert property (p_okay) else $error("bad bus response");

	c_cfg_write: cover property (wrOk && wrIdx_reg == 8'hf0);
	c_cfg_read: cover property (rdOk && reqIdx == 8'hf0);
	c_write_then_read: cover property (wrOk ##0 rdOk && reqIdx == wrIdx_reg);
endmodule : fcr_config_regs

`default_nettype wire

// ==== design/fcr_pkg.sv ====
// Constants of the floppy controller configuration register bank.
// Assumes an AHB-Lite bus with 32-bit data, one register per aligned word.
//
// Behaviour
// - Controller configuration resets to 24h.
// - Mode bit 6 clear: tape-drive bits 7-2 read all ones; set: enhanced.
// - Bit 5 sets density-select polarity at high rates; set means active high.
// - Bit 3 set blocks all drive writes regardless of the protect pin.
// - Bit 3 clear: write protection follows the external protect input only.
// - Bit 2 set selects legacy drive mode, clear the alternate mode.
// - Bit 0 set and device inactive: all controller outputs float.
// - Drive identification resets to 00h, read/write, bits 7-4 reserved.
// - Identification drives tape-drive bits 5-4 only in enhanced mode.
// - Drive 1 accessed: identification bits 3-2 appear on tape-drive bits 5-4.
// - Drive 0 accessed: identification bits 1-0 appear on tape-drive bits 5-4.
// - Base address high resets to 03h; bits 7-3 read zero.
// - Base address low resets to F2h; bits 2 and 0 read zero.
// - Interrupt type resets to 03h; only bit 1 writable.
// - Second-DMA report always reads 04h.
// - Activate resets to 00h; activity also needs both global enable bits.
// - Interrupt number and wake enable resets to 06h, read/write.

package fcr_pkg;
	// ----------------------------------------
	// Register indexes; byte address is four times the index
	// ----------------------------------------
	localparam logic [7:0] IDX_ACTIVATE = 8'h30;
	localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
	localparam logic [7:0] IDX_BASE_LOW = 8'h61;
	localparam logic [7:0] IDX_IRQ_NUM = 8'h70;
	localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
	localparam logic [7:0] IDX_DMA_SEL = 8'h74;
	localparam logic [7:0] IDX_DMA2_RPT = 8'h75;
	localparam logic [7:0] IDX_CFG = 8'hf0;
	localparam logic [7:0] IDX_IDENT = 8'hf1;

	// ----------------------------------------
	// Reset values and writable masks
	// ----------------------------------------
	localparam logic [7:0] RST_ACTIVATE = 8'h00;
	localparam logic [7:0] RST_BASE_HIGH = 8'h03;
	localparam logic [7:0] RST_BASE_LOW = 8'hf2;
	localparam logic [7:0] RST_IRQ_NUM = 8'h06;
	localparam logic [7:0] RST_IRQ_TYPE = 8'h03;
	localparam logic [7:0] RST_DMA_SEL = 8'h02;
	localparam logic [7:0] VAL_DMA2_RPT = 8'h04;
	localparam logic [7:0] RST_CFG = 8'h24;
	localparam logic [7:0] RST_IDENT = 8'h00;
	localparam logic [7:0] WMASK_BASE_HIGH = 8'h07;
	localparam logic [7:0] WMASK_BASE_LOW = 8'hfa;
	localparam logic [7:0] WMASK_IRQ_TYPE = 8'h02;
	localparam logic [7:0] WMASK_CFG = 8'h6d;
	localparam logic [7:0] WMASK_IDENT = 8'h0f;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CFG_ENHANCED = 6;
	localparam int CFG_DENS_POL = 5;
	localparam int CFG_FORCE_WP = 3;
	localparam int CFG_LEGACY_DRV = 2;
	localparam int CFG_FLOAT_EN = 0;
	localparam int ACT_ENABLE = 0;
	localparam logic [5:0] TAPE_LEGACY = 6'h3f;
endpackage : fcr_pkg

// ==== design/fcr_drive_ctrl.sv ====
// Drive-facing controls derived from the configuration bank.
// Assumes all inputs are already on clk_sys; outputs are registered.
`timescale 1ns/10ps
`default_nettype none

module fcr_drive_ctrl (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clkEn,
	// Configuration state
	input wire logic [7:0] cfgValue,
	input wire logic [3:0] identValue,
	input wire logic devActive,
	// Core and pin status
	input wire logic driveSelect,
	input wire logic highRate,
	input wire logic writeProtectSync,
	// Drive-side results
	output logic [5:0] tapeDriveHigh,
	output logic densitySelectOut,
	output logic writeBlocked,
	output logic altDriveMode,
	output logic outputsHiZ
);
	logic [1:0] identPair;

	// Pair of the accessed drive
	assign identPair = driveSelect ? identValue[3:2] : identValue[1:0];

	// Registered drive controls; reset follows the 24h configuration
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			tapeDriveHigh <= fcr_pkg::TAPE_LEGACY;
			densitySelectOut <= 1'b0;
			writeBlocked <= 1'b0;
			altDriveMode <= 1'b0;
			outputsHiZ <= 1'b0;
		end else if (clkEn) begin
			if (cfgValue[fcr_pkg::CFG_ENHANCED])
				tapeDriveHigh <= {2'b11, identPair, 2'b11};
			else
				tapeDriveHigh <= fcr_pkg::TAPE_LEGACY;
			densitySelectOut <= ~(highRate ^ cfgValue[fcr_pkg::CFG_DENS_POL]);
			writeBlocked <= cfgValue[fcr_pkg::CFG_FORCE_WP] | writeProtectSync;
			altDriveMode <= ~cfgValue[fcr_pkg::CFG_LEGACY_DRV];
			outputsHiZ <= cfgValue[fcr_pkg::CFG_FLOAT_EN] & ~devActive;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_legacy_tape;
		@(posedge clk_sys) disable iff (!reset_n)
		clkEn && !cfgValue[6] |=> tapeDriveHigh == 6'h3f;
	endproperty
	a_legacy_tape: assert property (p_legacy_tape) else $error("tape bits not legacy");
	property p_ident_pair;
		@(posedge clk_sys) disable iff (!reset_n)
		clkEn && cfgValue[6] |=> tapeDriveHigh[3:2] == (driveSelect ? identValue[3:2] : identValue[1:0])
			|| $past(driveSelect) != driveSelect || $changed(identValue);
	endproperty
	a_ident_pair: assert property (p_ident_pair) else $error("wrong ident pair");
	property p_force_wp;
		@(posedge clk_sys) disable iff (!reset_n)
		clkEn && cfgValue[3] |=> writeBlocked;
	endproperty
	a_force_wp: assert property (p_force_wp) else $error("forced protect ignored");
	property p_pin_wp;
		@(posedge clk_sys) disable iff (!reset_n)
		clkEn && !cfgValue[3] |=> writeBlocked == $past(writeProtectSync);
	endproperty
	a_pin_wp: assert property (p_pin_wp) else $error("protect not from pin");
	property p_float;
		@(posedge clk_sys) disable iff (!reset_n)
		clkEn |=> outputsHiZ == ($past(cfgValue[0]) && !$past(devActive));
	endproperty
	a_float: assert property (p_float) else $error("float control wrong");
	c_enhanced: cover property (@(posedge clk_sys) disable iff (!reset_n) tapeDriveHigh[3] == 1'b0);
endmodule : fcr_drive_ctrl

`default_nettype wire

// ==== tb/fcr_host_model.sv ====
// Host model: AHB-Lite master issuing single word register accesses.
// Assumes one slave whose hreadyout is looped back as hready.
`timescale 1ns/10ps
`default_nettype none

module fcr_host_model (
	// Clock
	input wire logic clk_sys,
	// AHB-Lite master side
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	// ----------------------------------------
	// Idle bus at time zero
	// ----------------------------------------
	initial begin
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h00000000;
	end

	// Caller sits just after an edge; address held until hready seen high
	task automatic addrPhase(input logic [7:0] idx, input logic isWrite);
		hsel <= 1'b1;
		haddr <= {22'h000000, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= isWrite;
		hsize <= 3'b010;
		hwdata <= $urandom; // Garbage outside the data phase
		do @(posedge clk_sys); while (hready !== 1'b1);
		htrans <= 2'b00;
	endtask : addrPhase

	// Single word write; reserved config bits 7 and 4 always sent as zero, bit 1 sent as given
	task automatic wr(input logic [7:0] idx, input logic [7:0] data);
		logic [7:0] d;
		d = (idx == fcr_pkg::IDX_CFG) ? (data & 8'h6f) : data;
		addrPhase(idx, 1'b1);
		hwdata <= {24'h000000, d};
		do @(posedge clk_sys); while (hready !== 1'b1);
	endtask : wr

	// Single word read; data taken at the closing edge
	task automatic rd(input logic [7:0] idx, output logic [31:0] data);
		addrPhase(idx, 1'b0);
		do @(posedge clk_sys); while (hready !== 1'b1);
		data = hrdata;
	endtask : rd
endmodule : fcr_host_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the floppy controller configuration bank.
// Assumes the host model drives the bus; bench drives the status pins.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk_sys, reset_n, clkEn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rdv;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic globalConfigOneEn, globalConfigSixEn, driveSelect, highRate, writeProtect_n;
	logic [15:0] baseAddress;
	logic [7:0] irqNumberWake, irqTypeSel, dmaChannel, c, id, a;
	logic deviceActive, enhancedMode, densitySelectOut, writeBlocked, altDriveMode, outputsHiZ;
	logic [5:0] tapeDriveHigh;
	logic [4:0] pins;
	int miscompares, checks_done, cycles;
	localparam int TIMEOUT_CYC = 20000;
	// Register table: index, reset value, writable mask
	logic [7:0] idxT [9] = '{fcr_pkg::IDX_ACTIVATE, fcr_pkg::IDX_BASE_HIGH, fcr_pkg::IDX_BASE_LOW,
		fcr_pkg::IDX_IRQ_NUM, fcr_pkg::IDX_IRQ_TYPE, fcr_pkg::IDX_DMA_SEL, fcr_pkg::IDX_DMA2_RPT,
		fcr_pkg::IDX_CFG, fcr_pkg::IDX_IDENT};
	logic [7:0] rstT [9] = '{8'h00, 8'h03, 8'hf2, 8'h06, 8'h03, 8'h02, 8'h04, 8'h24, 8'h00};
	logic [7:0] mskT [9] = '{8'hff, 8'h07, 8'hfa, 8'hff, 8'h02, 8'hff, 8'h00, 8'h6d, 8'h0f};
	logic [7:0] curT [9];

	assign hready = hreadyout;

	// Clock at 100 MHz
	always #5 clk_sys = ~clk_sys;

	fcr_host_model host (.clk_sys(clk_sys), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));

	fcr_config_regs #(.ADDR_W(32)) dut (.clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.globalConfigOneEn(globalConfigOneEn), .globalConfigSixEn(globalConfigSixEn),
		.driveSelect(driveSelect), .highRate(highRate), .writeProtect_n(writeProtect_n),
		.baseAddress(baseAddress), .irqNumberWake(irqNumberWake), .irqTypeSel(irqTypeSel),
		.dmaChannel(dmaChannel), .deviceActive(deviceActive), .tapeDriveHigh(tapeDriveHigh),
		.enhancedMode(enhancedMode), .densitySelectOut(densitySelectOut),
		.writeBlocked(writeBlocked), .altDriveMode(altDriveMode), .outputsHiZ(outputsHiZ));

	// ----------------------------------------
	// Checking and reporting
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test

	// Expected tape-drive bits 7..2; only bits 5-4 carry the drive pair
	function automatic logic [5:0] expTape(logic [7:0] cf, logic [7:0] di, logic ds);
		return cf[6] ? {2'b11, (ds ? di[3:2] : di[1:0]), 2'b11} : 6'h3f;
	endfunction : expTape

	// Reads every register against its reset value
	task automatic checkResetValues();
		for (int i = 0; i < 9; i++) begin
			host.rd(idxT[i], rdv);
			check(rdv, {24'h000000, rstT[i]}, "reset value");
		end
	endtask : checkResetValues

	// Hang guard: a stuck handshake ends the run as a failure
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == TIMEOUT_CYC) begin
			miscompares++;
			$display("[FAIL] %0t timeout", $time);
			finish_test();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		reset_n = 1'b0;
		clkEn = 1'b1;
		{globalConfigOneEn, globalConfigSixEn, driveSelect, highRate, writeProtect_n} = 5'b00001;
		miscompares = 0;
		checks_done = 0;
		cycles = 0;
		void'($urandom(40));
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		checkResetValues();
		// Random write then read back, through reserved and read-only bits
		for (int i = 0; i < 9; i++) begin
			c = $urandom;
			host.wr(idxT[i], c);
			if (idxT[i] == fcr_pkg::IDX_CFG) begin
				c = c & 8'h6f;
			end
			curT[i] = (rstT[i] & ~mskT[i]) | (c & mskT[i]);
			host.rd(idxT[i], rdv);
			check(rdv, {24'h000000, curT[i]}, "read back");
		end
		check(32'(baseAddress), {16'h0000, curT[1], curT[2]}, "base address out");
		check({irqNumberWake, irqTypeSel, dmaChannel, 8'h00}, {curT[3], curT[4], curT[5], 8'h00}, "irq dma out");
		// Unmapped index: write ignored, reads zero
		host.wr(8'h31, 8'hff);
		host.rd(8'h31, rdv);
		check(rdv, 32'h00000000, "unmapped read");
		check({31'h0, hresp}, 32'h00000000, "bus response");
		// Stalled bus while the clock enable is low
		clkEn <= 1'b0;
		@(posedge clk_sys);
		#1 check(32'(hreadyout), 32'h00000000, "ready while frozen");
		@(posedge clk_sys);
		clkEn <= 1'b1;
		@(posedge clk_sys);
		// Drive controls under random settings with corner cases first
		for (int i = 0; i < 40; i++) begin
			c = $urandom;
			id = $urandom;
			a = $urandom;
			if (i == 0) begin
				c = 8'h40;
				id = 8'h0a;
			end else if (i == 1) begin
				c = 8'hff;
				id = 8'hff;
			end
			host.wr(fcr_pkg::IDX_CFG, c);
			host.wr(fcr_pkg::IDX_IDENT, id);
			host.wr(fcr_pkg::IDX_ACTIVATE, a);
			pins = $urandom;
			{globalConfigOneEn, globalConfigSixEn, driveSelect, highRate, writeProtect_n} <= pins;
			repeat (5) @(posedge clk_sys);
			c = c & 8'h6d;
			host.rd(fcr_pkg::IDX_CFG, rdv);
			check(rdv, {24'h000000, c}, "config read");
			check(32'(tapeDriveHigh), 32'(expTape(c, id, pins[2])), "tape drive bits");
			check(32'(enhancedMode), 32'(c[6]), "enhanced mode");
			check({31'h0, densitySelectOut}, {31'h0, pins[1] ? c[5] : ~c[5]}, "density select");
			check({31'h0, writeBlocked}, {31'h0, c[3] | ~pins[0]}, "write blocked");
			check({31'h0, altDriveMode}, {31'h0, ~c[2]}, "drive mode");
			check(32'(deviceActive), 32'(a[0] & pins[4] & pins[3]), "device active");
			check(32'(outputsHiZ), 32'(c[0] & ~(a[0] & pins[4] & pins[3])), "outputs float");
		end
		// Second reset in mid-run restores every register
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		checkResetValues();
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
